// ### verilog/fgp_port.sv
// What this block does
// - four pins, the lower three usable either direction
// - direction one: driver off, pin input, unless lcd or ccp claims the pin and drives it
// - direction zero: drive latch onto pin, unless lcd or ccp claims it
// - fourth pin input only, direction reads one
// - port read gives pins, write hits latch
// - port writes load the written bits straight into latch
// - input-only pin reads zero under master clear
// - analog select forces digital reads to zero
// - analog select leaves digital output untouched
// - direction still gates latch driver in analog mode; lcd and ccp claims drive regardless
// - analog select resets to one on lower pins
// - analog select bits two to zero
// - priority: lcd, then ccp, then latch
// - analog and digital inputs stay active whatever the direction
// - latch readable, writable, kept through ordinary resets, cleared by power-on
// - unimplemented upper bits ignore writes, read zero
module fgp_port
#(
	parameter int PINS = 4
)
(
	// system
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic por_n_i,
	// register port
	input wire fgp_pkg::fgp_bus_type bus_i,
	output logic [7:0] rdata_o,
	// configuration
	input wire logic master_clear_pin_enable_i,
	// peripherals on the lower pins
	input wire fgp_pkg::fgp_periph_type [2:0] periph_i,
	// pins
	input wire logic [3:0] pin_i,
	output logic [2:0] pin_o,
	output logic [2:0] pin_oe_o,
	// digital input view for peripherals
	output logic [3:0] digital_in_o,
	output logic [2:0] analog_sel_o
);
	import fgp_pkg::*;

	initial
	begin
		if (PINS != FGP_PINS)
			$error("fgp_port supports exactly four pins");
	end

	logic [2:0] dir_reg;
	logic [2:0] dir_next;
	logic [2:0] latch_reg;
	logic [2:0] latch_next;
	logic [2:0] analog_reg;
	logic [2:0] analog_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [3:0] pin_view;

	// digital view of the pins, analog and master clear masked
	function automatic logic [3:0] fgp_digital
	(
		input logic [3:0] pins,
		input logic [2:0] analog,
		input logic mclr
	);
		logic [3:0] v;
		v[2:0] = pins[2:0] & ~analog;
		v[3] = pins[3] & ~mclr;
		return v;
	endfunction : fgp_digital

	// inputs keep working whatever the driver does
	assign pin_view = fgp_digital(pin_i, analog_reg, master_clear_pin_enable_i);
	assign digital_in_o = pin_view;
	assign analog_sel_o = analog_reg;

	always_comb
	begin
		dir_next = dir_reg;
		latch_next = latch_reg;
		analog_next = analog_reg;
		rdata_next = rdata_reg;
		if (bus_i.wr)
		begin
			if (bus_i.addr == FGP_ADDR_PORT)
				latch_next = bus_i.wdata[2:0];
			else if (bus_i.addr == FGP_ADDR_LATCH)
				latch_next = bus_i.wdata[2:0];
			else if (bus_i.addr == FGP_ADDR_DIR)
				dir_next = bus_i.wdata[2:0];
			else if (bus_i.addr == FGP_ADDR_ANALOG)
				analog_next = bus_i.wdata[2:0];
		end
		if (bus_i.rd)
		begin
			if (bus_i.addr == FGP_ADDR_PORT)
				rdata_next = {4'h0, pin_view};
			else if (bus_i.addr == FGP_ADDR_DIR)
				rdata_next = {4'h0, 1'b1, dir_reg};
			else if (bus_i.addr == FGP_ADDR_LATCH)
				rdata_next = {5'h00, latch_reg};
			else if (bus_i.addr == FGP_ADDR_ANALOG)
				rdata_next = {5'h00, analog_reg};
			else
				rdata_next = FGP_UNMAPPED_READ;
		end
		else
			rdata_next = 8'h00;
	end

	// latch survives ordinary resets, cleared only by power-on
	always_ff @(posedge clk_sys_i)
	begin
		if (!por_n_i)
			latch_reg <= FGP_LATCH_POR;
		else
			latch_reg <= latch_next;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i || !por_n_i)
		begin
			dir_reg <= FGP_DIR_RESET;
			analog_reg <= FGP_ANALOG_RESET;
			rdata_reg <= 8'h00;
		end
		else
		begin
			dir_reg <= dir_next;
			analog_reg <= analog_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_o = rdata_reg;

	// direction gates the latch driver even in analog mode; lcd and ccp claims always drive
	genvar g;
	generate
		for (g = 0; g < FGP_LOWER; g++)
		begin : g_pin
			fgp_pin_mux u_mux
			(
				.periph_i(periph_i[g]),
				.latch_i(latch_reg[g]),
				.dir_in_i(dir_reg[g]),
				.src_o(),
				.out_o(pin_o[g]),
				.oe_o(pin_oe_o[g])
			);
		end
	endgenerate

endmodule : fgp_port

// ### verilog/fgp_pkg.sv
package fgp_pkg;

	// register map (chosen offsets)
	localparam logic [3:0] FGP_ADDR_PORT = 4'h0;
	localparam logic [3:0] FGP_ADDR_DIR = 4'h1;
	localparam logic [3:0] FGP_ADDR_LATCH = 4'h2;
	localparam logic [3:0] FGP_ADDR_ANALOG = 4'h3;

	localparam int FGP_PINS = 4;
	localparam int FGP_LOWER = 3;
	localparam int FGP_INPUT_ONLY_BIT = 3;

	localparam logic [2:0] FGP_DIR_RESET = 3'h7;
	localparam logic [2:0] FGP_ANALOG_RESET = 3'h7;
	localparam logic [2:0] FGP_LATCH_POR = 3'h0;
	localparam logic [7:0] FGP_UNMAPPED_READ = 8'h00;

	typedef enum logic [1:0]
	{
		FGP_SRC_LATCH = 2'b00,
		FGP_SRC_CCP = 2'b01,
		FGP_SRC_LCD = 2'b10
	} fgp_src_type;

	// one pin's peripheral claims
	typedef struct packed
	{
		logic lcd_en;
		logic lcd_val;
		logic ccp_en;
		logic ccp_val;
	} fgp_periph_type;

	typedef struct packed
	{
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fgp_bus_type;

endpackage : fgp_pkg

// ### verilog/fgp_pin_mux.sv
module fgp_pin_mux
(
	// claims
	input wire fgp_pkg::fgp_periph_type periph_i,
	input wire logic latch_i,
	input wire logic dir_in_i,
	// result
	output fgp_pkg::fgp_src_type src_o,
	output logic out_o,
	output logic oe_o
);
	import fgp_pkg::*;

	always_comb
	begin
		if (periph_i.lcd_en)
		begin
			src_o = FGP_SRC_LCD;
			out_o = periph_i.lcd_val;
			oe_o = 1'b1;
		end
		else if (periph_i.ccp_en)
		begin
			src_o = FGP_SRC_CCP;
			out_o = periph_i.ccp_val;
			oe_o = 1'b1;
		end
		else
		begin
			src_o = FGP_SRC_LATCH;
			out_o = latch_i;
			oe_o = ~dir_in_i;
		end
	end

endmodule : fgp_pin_mux

// ### verif/fgp_assertions.sv
module fgp_checker import fgp_pkg::*;
(
	// watched ports
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire fgp_bus_type bus_i,
	input wire logic [7:0] rdata_o,
	input wire logic master_clear_pin_enable_i,
	input wire fgp_periph_type [2:0] periph_i,
	input wire logic [2:0] pin_o,
	input wire logic [2:0] pin_oe_o,
	input wire logic [3:0] digital_in_o,
	input wire logic [2:0] analog_sel_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	lcd_wins_a: assert property (periph_i[1].lcd_en |-> pin_o[1] == periph_i[1].lcd_val)
		else $error("lcd lost pin");
	ccp_next_a: assert property (periph_i[1] ==? 4'b0?1? |-> pin_oe_o[1] && pin_o[1] == periph_i[1].ccp_val)
		else $error("ccp lost pin");
	read_idle_a: assert property (!$past(bus_i.rd) |-> !rdata_o)
		else $error("stray data");
	mclr_zero_a: assert property (master_clear_pin_enable_i |-> !digital_in_o[3])
		else $error("pin3 high");
	analog_zero_a: assert property (!(digital_in_o[2:0] & analog_sel_o))
		else $error("analog reads one");
	analog_reset_a: assert property ($rose(rst_n_i) |-> &analog_sel_o)
		else $error("analog reset");
	analog_write_a: assert property (bus_i.wr && bus_i.addr == FGP_ADDR_ANALOG
		|=> analog_sel_o == $past(bus_i.wdata[2:0])) else $error("analog write");
	port_read_a: assert property (bus_i.rd && bus_i.addr == FGP_ADDR_PORT
		|=> rdata_o == {4'h0, $past(digital_in_o)}) else $error("port read");
	cover property (bus_i.wr);
	cover property (periph_i[1].ccp_en);
	cover property (master_clear_pin_enable_i);
endmodule : fgp_checker

bind fgp_port fgp_checker chk (.*);

// ### verif/fgp_pin_model.sv
module fgp_pin_model
(
	// port side
	input wire logic [2:0] pin_o,
	input wire logic [2:0] pin_oe_o,
	// far side
	input wire logic [3:0] ext_i,
	output logic [3:0] pin_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// released pins follow the outside level
	assign pin_i = {ext_i[3], pin_oe_o & pin_o | ~pin_oe_o & ext_i[2:0]};
endmodule : fgp_pin_model

// ### verif/testbench.sv
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; $display("BAD %0t %h %h", $time, a, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import fgp_pkg::*;
	logic clk_sys_i = 0, rst_n_i = 0, por_n_i = 0, master_clear_pin_enable_i = 0;
	fgp_bus_type bus_i = '0;
	fgp_periph_type [2:0] periph_i = '0;
	logic [3:0] ext_i = 4'hf, pin_i, digital_in_o;
	logic [7:0] rdata_o;
	logic [2:0] pin_o, pin_oe_o, analog_sel_o;
	int error_cnt = 0, comparisons = 0;
	fgp_port dut (.*);
	fgp_pin_model far (.*);
	initial forever #20 clk_sys_i = ~clk_sys_i;
	// writes also check that read data stays low
	task automatic op(input logic [3:0] a, input logic [7:0] d, input logic w, input logic [7:0] e);
		@(posedge clk_sys_i) bus_i <= '{a, d, w, !w};
		@(posedge clk_sys_i) bus_i <= '0;
		#1 `CHK(rdata_o, e)
	endtask : op
	task automatic t_drive;
		op(FGP_ADDR_LATCH, 8'hf5, 1'b1, 8'h00);
		op(FGP_ADDR_DIR, 8'h00, 1'b1, 8'h00);
		op(FGP_ADDR_DIR, 8'h00, 1'b0, 8'h08);
		`CHK({pin_oe_o, pin_o}, 6'h3d)
		op(FGP_ADDR_PORT, 8'h00, 1'b0, 8'h08);
		op(FGP_ADDR_ANALOG, 8'hf8, 1'b1, 8'h00);
		op(FGP_ADDR_ANALOG, 8'h00, 1'b0, 8'h00);
		op(FGP_ADDR_PORT, 8'h00, 1'b0, 8'h0d);
		@(posedge clk_sys_i) master_clear_pin_enable_i <= 1'b1;
		op(FGP_ADDR_PORT, 8'h02, 1'b1, 8'h00);
		op(FGP_ADDR_PORT, 8'h00, 1'b0, 8'h02);
	endtask : t_drive
	task automatic t_prio(input logic [3:0] c, input logic e);
		@(posedge clk_sys_i) periph_i[1] <= c;
		#1 `CHK(pin_o[1], e)
	endtask : t_prio
	// latch must survive a warm reset
	task automatic t_warm;
		@(posedge clk_sys_i) rst_n_i <= 1'b0;
		@(posedge clk_sys_i) rst_n_i <= 1'b1;
		#1 `CHK(pin_oe_o, 3'h0)
		op(FGP_ADDR_LATCH, 8'h00, 1'b0, 8'h02);
		op(FGP_ADDR_DIR, 8'h00, 1'b0, 8'h0f);
		op(FGP_ADDR_ANALOG, 8'h00, 1'b0, 8'h07);
	endtask : t_warm
	task automatic test_done;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (5) @(posedge clk_sys_i);
		{rst_n_i, por_n_i} <= 2'h3;
		t_drive;
		t_prio(4'hb, 1'b0);
		t_prio(4'h2, 1'b0);
		t_prio(4'h0, 1'b1);
		t_warm;
		test_done;
	end
	initial
	begin
		#20000;
		error_cnt++;
		test_done;
	end
endmodule : testbench
